// File: timer_baud.sv
// Timer 1 baud generator, Timer 0/3 flags and external interrupt pending.
// Assumes a classic Wishbone master and a serial port using the ticks.
`timescale 1ns/1ps

module timer_baud (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer1_external_count_input_i,
    input wire logic ext_osc_i,
    input wire logic timer0_tick_i,
    input wire logic rx_i,
    input wire logic ext_int0_i,
    input wire logic ext_int1_i,
    output logic tx_tick_o,
    output logic rx_tick_o,
    output logic irq_o
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] t3_ctrl_r;
    logic [7:0] timer1_reload_byte_r;
    logic [2:0] t1_src_r;
    logic [7:0] timer0_count_r;
    logic [15:0] t3_count_r;
    localparam int ev_mask_w = timer_pkg::ev_count;
    logic [ev_mask_w-1:0] irq_mask_r;
    logic [ev_mask_w-1:0] irq_stat_r;
    logic [ev_mask_w-1:0] irq_stat_nxt;
    logic ack_r;
    logic [31:0] rdata_r;
    logic rx_d_r;
    logic x0_d_r;
    logic x1_d_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] t3_ctrl_nxt;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Single-cycle answer: ack comes one edge after the request appears.
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    wire wr_lo = bus_req && wb_we_i && wb_sel_i[0];
    wire wr_ctrl = wr_lo && (wb_adr_i == timer_pkg::run_flag_ctrl_addr);
    wire wr_t3 = wr_lo && (wb_adr_i == timer_pkg::timer3_ctrl_addr);
    wire wr_cfg = bus_req && wb_we_i && (wb_adr_i == timer_pkg::timer1_cfg_addr);
    wire wr_stat = wr_lo && (wb_adr_i == timer_pkg::irq_status_addr);
    wire wr_mask = wr_lo && (wb_adr_i == timer_pkg::irq_mask_addr);
    wire wr_vec = wr_lo && (wb_adr_i == timer_pkg::vector_ack_addr);
    wire [2:0] vec_code = wb_dat_i[2:0];
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // ------------------------------------------------------------------
    // Timer 1 and receive duplicate
    // ------------------------------------------------------------------
    wire t1_run = ctrl_r[timer_pkg::tr1_bit];
    wire t1_tick;
    wire t1_ovf;
    wire rx_ovf;
    wire rx_start = rx_d_r && !rx_i && t1_run;
    wire [7:0] timer1_low_count;

    clk_prescaler u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(t1_src_r),
        .ext_osc_i(ext_osc_i),
        .ext_pin_i(timer1_external_count_input_i),
        .tick_o(t1_tick)
    );

    // Transmit side runs on the visible low count.
    reload_counter u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(t1_run),
        .tick_i(t1_tick),
        .force_i(1'b0),
        .reload_i(timer1_reload_byte_r),
        .count_o(timer1_low_count),
        .ovf_o(t1_ovf),
        .half_o(tx_tick_o)
    );

    // Hidden duplicate, same run and reload, restarted by start edge.
    reload_counter u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(t1_run),
        .tick_i(t1_tick),
        .force_i(rx_start),
        .reload_i(timer1_reload_byte_r),
        .count_o(),
        .ovf_o(rx_ovf),
        .half_o(rx_tick_o)
    );

    // ------------------------------------------------------------------
    // Timer 0 (plain 8-bit count) and Timer 3
    // ------------------------------------------------------------------
    wire t0_ovf = ctrl_r[timer_pkg::tr0_bit] && timer0_tick_i && (timer0_count_r == 8'hff);
    wire t3_split = t3_ctrl_r[timer_pkg::timer3_split_select_bit];
    wire t3_run = t3_ctrl_r[timer_pkg::tr3_bit];
    wire t3_lo_ovf = t3_split && (t3_count_r[7:0] == 8'hff);
    wire t3_hi_run = t3_run;
    wire t3_hi_ovf = t3_split ? (t3_hi_run && t3_count_r[15:8] == 8'hff)
                              : (t3_run && t3_count_r == 16'hffff);
    wire x0_edge = ext_int0_i && !x0_d_r;
    wire x1_edge = ext_int1_i && !x1_d_r;
    wire x0_set = ctrl_r[timer_pkg::it0_bit] ? x0_edge : ext_int0_i;
    wire x1_set = ctrl_r[timer_pkg::it1_bit] ? x1_edge : ext_int1_i;

    // Flag next values: set wins over any clear in the same cycle.
    always_comb begin
        ctrl_nxt = wr_ctrl ? wb_dat_i[7:0] : ctrl_r;
        if (wr_vec && vec_code == timer_pkg::ack_t0) begin
            ctrl_nxt[timer_pkg::tf0_bit] = 1'b0;
        end
        if (wr_vec && vec_code == timer_pkg::ack_t1) begin
            ctrl_nxt[timer_pkg::tf1_bit] = 1'b0;
        end
        if (wr_vec && vec_code == timer_pkg::ack_x0 && ctrl_r[timer_pkg::it0_bit]) begin
            ctrl_nxt[timer_pkg::ie0_bit] = 1'b0;
        end
        if (wr_vec && vec_code == timer_pkg::ack_x1 && ctrl_r[timer_pkg::it1_bit]) begin
            ctrl_nxt[timer_pkg::ie1_bit] = 1'b0;
        end
        if (!ctrl_r[timer_pkg::it0_bit]) begin
            ctrl_nxt[timer_pkg::ie0_bit] = ext_int0_i; // Level mode follows the input.
        end
        if (!ctrl_r[timer_pkg::it1_bit]) begin
            ctrl_nxt[timer_pkg::ie1_bit] = ext_int1_i;
        end
        if (t1_ovf) begin
            ctrl_nxt[timer_pkg::tf1_bit] = 1'b1;
        end
        if (t0_ovf) begin
            ctrl_nxt[timer_pkg::tf0_bit] = 1'b1;
        end
        if (x0_set) begin
            ctrl_nxt[timer_pkg::ie0_bit] = 1'b1;
        end
        if (x1_set) begin
            ctrl_nxt[timer_pkg::ie1_bit] = 1'b1;
        end
        // Timer 3 flags change only by software write or hardware set.
        t3_ctrl_nxt = wr_t3 ? (wb_dat_i[7:0] & 8'hfd) : t3_ctrl_r;
        if (t3_hi_ovf) begin
            t3_ctrl_nxt[timer_pkg::timer3_high_overflow_flag_bit] = 1'b1;
        end
        if (t3_lo_ovf) begin
            t3_ctrl_nxt[timer_pkg::timer3_low_overflow_flag_bit] = 1'b1;
        end
    end

    // Sticky status, write one to clear, events win over the clear.
    always_comb begin
        irq_stat_nxt = wr_stat ? (irq_stat_r & ~wb_dat_i[ev_mask_w-1:0]) : irq_stat_r;
        irq_stat_nxt[timer_pkg::ev_t0] = irq_stat_nxt[timer_pkg::ev_t0] | t0_ovf;
        irq_stat_nxt[timer_pkg::ev_t1] = irq_stat_nxt[timer_pkg::ev_t1] | t1_ovf;
        irq_stat_nxt[timer_pkg::ev_t3h] = irq_stat_nxt[timer_pkg::ev_t3h] | t3_hi_ovf;
        irq_stat_nxt[timer_pkg::ev_t3l] = irq_stat_nxt[timer_pkg::ev_t3l] | t3_lo_ovf;
        irq_stat_nxt[timer_pkg::ev_x0] = irq_stat_nxt[timer_pkg::ev_x0] | x0_set;
        irq_stat_nxt[timer_pkg::ev_x1] = irq_stat_nxt[timer_pkg::ev_x1] | x1_set;
    end

    // Any sticky status bit reaches the interrupt line while unmasked.
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // Read mux.
    wire [31:0] rd_mux =
        (wb_adr_i == timer_pkg::run_flag_ctrl_addr) ? {24'h000000, ctrl_r} :
        (wb_adr_i == timer_pkg::timer3_ctrl_addr) ? {24'h000000, t3_ctrl_r} :
        (wb_adr_i == timer_pkg::timer1_cfg_addr) ?
            {13'h0000, t1_src_r, timer1_low_count, timer1_reload_byte_r} :
        (wb_adr_i == timer_pkg::timer3_count_addr) ? {16'h0000, t3_count_r} :
        (wb_adr_i == timer_pkg::irq_status_addr) ? {26'h0000000, irq_stat_r} :
        (wb_adr_i == timer_pkg::irq_mask_addr) ? {26'h0000000, irq_mask_r} :
        32'h00000000;

    // ------------------------------------------------------------------
    // State update
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= timer_pkg::ctrl_reset;
            t3_ctrl_r <= timer_pkg::t3_ctrl_reset;
            timer1_reload_byte_r <= 8'h00;
            t1_src_r <= 3'h0;
            irq_mask_r <= '0;
            irq_stat_r <= '0;
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            t3_ctrl_r <= t3_ctrl_nxt;
            irq_stat_r <= irq_stat_nxt;
            ack_r <= bus_req;
            rdata_r <= bus_req ? rd_mux : rdata_r;
            if (wr_cfg && wb_sel_i[0]) begin
                timer1_reload_byte_r <= wb_dat_i[7:0];
            end
            if (wr_cfg && wb_sel_i[2]) begin
                t1_src_r <= (wb_dat_i[18:16] > 3'h5) ? 3'h0 : wb_dat_i[18:16];
            end
            if (wr_mask) begin
                irq_mask_r <= wb_dat_i[ev_mask_w-1:0];
            end
        end
    end

    // Counters and edge history.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer0_count_r <= 8'h00;
            t3_count_r <= 16'h0000;
            rx_d_r <= 1'b1;
            x0_d_r <= 1'b0;
            x1_d_r <= 1'b0;
        end else begin
            rx_d_r <= rx_i;
            x0_d_r <= ext_int0_i;
            x1_d_r <= ext_int1_i;
            if (ctrl_r[timer_pkg::tr0_bit] && timer0_tick_i) begin
                timer0_count_r <= timer0_count_r + 8'h01;
            end
            if (t3_split) begin
                t3_count_r[7:0] <= t3_count_r[7:0] + 8'h01;
                if (t3_hi_run) begin
                    t3_count_r[15:8] <= t3_count_r[15:8] + 8'h01;
                end
            end else if (t3_run) begin
                t3_count_r <= t3_count_r + 16'h0001;
            end
        end
    end
endmodule // timer_baud

// File: timer_pkg.sv
// Package of constants and carriers for the timer and baud tick block.
// Assumes a single 20 MHz clock domain and a classic Wishbone register bus.
package timer_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one word each, aligned except timer3_ctrl_addr at 8'h91)
    // ------------------------------------------------------------------
    localparam logic [7:0] run_flag_ctrl_addr = 8'h88;
    localparam logic [7:0] timer3_ctrl_addr = 8'h91;
    localparam logic [7:0] timer1_cfg_addr = 8'h8c;
    localparam logic [7:0] timer3_count_addr = 8'h94;
    localparam logic [7:0] irq_status_addr = 8'ha0;
    localparam logic [7:0] irq_mask_addr = 8'ha4;
    localparam logic [7:0] vector_ack_addr = 8'ha8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int tf1_bit = 7;
    localparam int tr1_bit = 6;
    localparam int tf0_bit = 5;
    localparam int tr0_bit = 4;
    localparam int ie1_bit = 3;
    localparam int it1_bit = 2;
    localparam int ie0_bit = 1;
    localparam int it0_bit = 0;
    localparam int timer3_high_overflow_flag_bit = 7;
    localparam int timer3_low_overflow_flag_bit = 6;
    localparam int timer3_split_select_bit = 3;
    localparam int tr3_bit = 2;

    // Interrupt status bits.
    localparam int ev_t0 = 0;
    localparam int ev_t1 = 1;
    localparam int ev_t3h = 2;
    localparam int ev_t3l = 3;
    localparam int ev_x0 = 4;
    localparam int ev_x1 = 5;
    localparam int ev_count = 6;

    // Vector acknowledge codes written to vector_ack_addr.
    localparam logic [2:0] ack_t0 = 3'h1;
    localparam logic [2:0] ack_t1 = 3'h2;
    localparam logic [2:0] ack_x0 = 3'h3;
    localparam logic [2:0] ack_x1 = 3'h4;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] t3_ctrl_reset = 8'h00;
    localparam int clk_mhz = 20;
    localparam logic [7:0] reload_wrap = 8'hff;

    // Timer 1 count clock selections.
    typedef enum logic [2:0] {
        src_sys, src_div4, src_div12, src_div48, src_ext_osc8, src_ext_pin
    } t1_src_t;

    // Baud ticks handed to the serial port.
    typedef struct packed {
        logic tx_tick;
        logic rx_tick;
    } baud_t;

    // Wishbone request carrier.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// File: clk_prescaler.sv
// Count-clock enable generator for Timer 1.
// Assumes external inputs are already synchronous to clk_i.
`timescale 1ns/1ps
module clk_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] sel_i,
    input wire logic ext_osc_i,
    input wire logic ext_pin_i,
    output logic tick_o
);
    logic [5:0] div_r;
    logic [2:0] osc_div_r;
    logic osc_d_r;
    logic pin_d_r;
    wire osc_rise = ext_osc_i & ~osc_d_r;
    wire pin_rise = ext_pin_i & ~pin_d_r;

    // Free divider; external oscillator divided by 8 on its rising edges.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= 6'h00;
            osc_div_r <= 3'h0;
            osc_d_r <= 1'b0;
            pin_d_r <= 1'b0;
        end else begin
            div_r <= (div_r == 6'h2f) ? 6'h00 : div_r + 6'h01;
            osc_div_r <= osc_div_r + {2'h0, osc_rise};
            osc_d_r <= ext_osc_i;
            pin_d_r <= ext_pin_i;
        end
    end

    // Six count clock choices.
    always_comb begin
        unique case (sel_i)
            3'h0: tick_o = 1'b1;
            3'h1: tick_o = (div_r[1:0] == 2'h3);
            3'h2: tick_o = (div_r == 6'h0b) || (div_r == 6'h17) || (div_r == 6'h23)
                           || (div_r == 6'h2f);
            3'h3: tick_o = (div_r == 6'h2f);
            3'h4: tick_o = osc_rise && (osc_div_r == 3'h7);
            3'h5: tick_o = pin_rise;
            default: tick_o = 1'b0;
        endcase
    end
endmodule // clk_prescaler

// File: reload_counter.sv
// Eight-bit auto-reload counter with halving flop on overflow.
// Assumes tick_i is a one-cycle count enable.
`timescale 1ns/1ps
module reload_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic force_i,
    input wire logic [7:0] reload_i,
    output logic [7:0] count_o,
    output logic ovf_o,
    output logic half_o
);
    logic half_r;
    assign ovf_o = run_i && tick_i && (count_o == timer_pkg::reload_wrap) && !force_i;
    assign half_o = ovf_o && half_r;

    // Count up; reload on overflow or on a forced restart.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 8'h00;
            half_r <= 1'b0;
        end else if (force_i) begin
            count_o <= reload_i;
            half_r <= 1'b0;
        end else if (run_i && tick_i) begin
            count_o <= ovf_o ? reload_i : count_o + 8'h01;
            if (ovf_o) begin
                half_r <= ~half_r;
            end
        end
    end
endmodule // reload_counter

// File: timer_baud_props.sv
// Checker of the bus answer and the tick and interrupt outputs of timer_baud.
// Assumes it is bound to every timer_baud and sees its ports only.
`timescale 1ns/1ps
module timer_baud_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_tick_o,
    input wire logic rx_tick_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // The answer is a one-cycle pulse tied to a request taken the cycle before.
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
    a_ack_has_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_req_answered: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("request not acked");
    a_idle_no_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack while bus idle");
    // Read data may only move after a request, so software never sees it drift.
    a_data_stands: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(wb_cyc_i && wb_stb_i && !wb_ack_o) |-> $stable(wb_dat_o))
        else $error("read data moved without request");
    // Reset leaves ack, irq and both ticks quiet; checked without the reset disable.
    a_reset_quiet: assert property (@(posedge clk_i)
        rst_i |=> (!wb_ack_o && !irq_o && !tx_tick_o && !rx_tick_o))
        else $error("outputs active after reset");
    // Halved overflows can never give two ticks in a row.
    a_tx_halved: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_tick_o |=> !tx_tick_o) else $error("tx tick on consecutive cycles");
    a_rx_halved: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_tick_o |=> !rx_tick_o) else $error("rx tick on consecutive cycles");
endmodule // timer_baud_props

bind timer_baud timer_baud_props u_timer_baud_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .tx_tick_o(tx_tick_o),
    .rx_tick_o(rx_tick_o),
    .irq_o(irq_o)
);

// File: serial_partner.sv
// Model of the serial receiver line that feeds the baud block.
// Assumes start_i is a one-cycle command from the bench.
`timescale 1ns/1ps
module serial_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic rx_o
);
    // ------------------------------------------------------------------
    // Start bit
    // ------------------------------------------------------------------
    logic [2:0] low_r = 3'h0;

    // A start holds the idle-high line low for four cycles, long enough to be seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_r <= 3'h0;
        end else if (start_i) begin
            low_r <= 3'h4;
        end else if (low_r != 3'h0) begin
            low_r <= low_r - 3'h1;
        end
    end
    assign rx_o = (low_r == 3'h0);
endmodule // serial_partner

// File: tb.sv
// Self-checking bench of timer_baud over classic Wishbone.
// Assumes the serial_partner model and the bound checker are compiled with it.
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic ext_osc_i = 1'b0;
    logic pin_i = 1'b0;
    logic int0_i = 1'b0;
    logic int1_i = 1'b0;
    logic start = 1'b0;
    logic rx_line, wb_ack_o, tx_tick_o, rx_tick_o, irq_o;
    logic [31:0] wb_dat_o;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int fac[6] = '{1, 4, 12, 48, 16, 2};

    timer_baud u_timer_baud (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .timer1_external_count_input_i(pin_i), .ext_osc_i(ext_osc_i), .timer0_tick_i(1'b0),
        .rx_i(rx_line), .ext_int0_i(int0_i), .ext_int1_i(int1_i), .tx_tick_o(tx_tick_o),
        .rx_tick_o(rx_tick_o), .irq_o(irq_o));
    serial_partner u_serial_partner (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
        .rx_o(rx_line));

    // Clock, free-running count sources and a hang guard of 100000 cycles.
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        ext_osc_i <= ~ext_osc_i;
        pin_i <= ~pin_i;
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_int(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic cycle; the answer is taken at the edge that shows ack high.
    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        chk_byte(q[7:0] & m, e);
    endtask
    // Cycles from one tick to the next on the chosen output.
    task automatic gap(input bit rx, output int n);
        do @(posedge clk_i); while ((rx ? rx_tick_o : tx_tick_o) !== 1'b1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((rx ? rx_tick_o : tx_tick_o) !== 1'b1);
    endtask
    // Start bit w cycles after a tx tick; early ticks before the reload are skipped.
    task automatic rx_start(input int w, output int d);
        int g;
        gap(1'b0, g);
        repeat (w) @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        d = 0;
        while (rx_tick_o !== 1'b1 || d < 4) begin
            @(posedge clk_i);
            d++;
        end
    endtask
    task automatic irq_is(input logic e);
        @(negedge clk_i);
        chk_byte({7'h0, irq_o}, {7'h0, e});
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        int g;
        int d1;
        int d2;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(timer_pkg::run_flag_ctrl_addr, 8'hff, 8'h00);
        rd(timer_pkg::timer3_ctrl_addr, 8'hff, 8'h00);
        wr(8'h04, 32'hff);
        rd(8'h04, 8'hff, 8'h00);
        wr(timer_pkg::run_flag_ctrl_addr, 32'h40);
        for (int s = 0; s < 6; s++) begin
            wr(timer_pkg::timer1_cfg_addr, {13'h0, s[2:0], 16'h00f0});
            gap(1'b0, g);
            gap(1'b0, g);
            chk_int(g, 2 * (256 - 240) * fac[s]);
        end
        wr(timer_pkg::timer1_cfg_addr, 32'h00f0);
        rx_start(3, d1);
        rx_start(8, d2);
        chk_int(d1 % 16, d2 % 16);
        gap(1'b1, g);
        chk_int(g, 32);
        wr(timer_pkg::run_flag_ctrl_addr, 32'h80);
        rd(timer_pkg::run_flag_ctrl_addr, 8'hff, 8'h80);
        wr(timer_pkg::vector_ack_addr, {29'h0, timer_pkg::ack_t1});
        rd(timer_pkg::run_flag_ctrl_addr, 8'hff, 8'h00);
        wr(timer_pkg::irq_mask_addr, 32'h1 << timer_pkg::ev_t1);
        irq_is(1'b1);
        wr(timer_pkg::irq_status_addr, 32'h1 << timer_pkg::ev_t1);
        irq_is(1'b0);
        wr(timer_pkg::run_flag_ctrl_addr, 32'h01);
        int0_i <= 1'b1;
        @(posedge clk_i);
        int0_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(timer_pkg::run_flag_ctrl_addr, 8'hff, 8'h03);
        wr(timer_pkg::vector_ack_addr, {29'h0, timer_pkg::ack_x0});
        rd(timer_pkg::run_flag_ctrl_addr, 8'hff, 8'h01);
        int1_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(timer_pkg::run_flag_ctrl_addr, 8'hff, 8'h09);
        int1_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(timer_pkg::run_flag_ctrl_addr, 8'hff, 8'h01);
        wr(timer_pkg::timer3_ctrl_addr, 32'h08);
        repeat (600) @(posedge clk_i);
        rd(timer_pkg::timer3_ctrl_addr, 8'h40, 8'h40);
        wr(timer_pkg::timer3_ctrl_addr, 32'h04);
        wr(timer_pkg::irq_status_addr, 32'h1 << timer_pkg::ev_t3h);
        wr(timer_pkg::irq_mask_addr, 32'h1 << timer_pkg::ev_t3h);
        while (irq_o !== 1'b1) @(posedge clk_i);
        irq_is(1'b1);
        repeat (100) @(posedge clk_i);
        rd(timer_pkg::timer3_ctrl_addr, 8'h80, 8'h80);
        wr(timer_pkg::timer3_ctrl_addr, 32'h00);
        rd(timer_pkg::timer3_ctrl_addr, 8'h80, 8'h00);
        give_verdict();
    end
endmodule // tb
